//--- verilog/sram_host_pkg.sv
// shared constants and types of the burst sram host controller
package sram_host_pkg;
  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_LO_MSB = 8;   // lane 0 covers bits 8:0
  localparam int LANE_HI_LSB = 9;   // lane 1 covers bits 17:9
  localparam int ADDR_W_DEF = 21;
  // ----------------------------------------------------------------
  // link clock phases, four system clocks per link clock period
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_HI0 = 2'h0;  // link clock just rose
  localparam logic [1:0] PH_HI1 = 2'h1;
  localparam logic [1:0] PH_LO0 = 2'h2;  // complement clock just rose
  localparam logic [1:0] PH_LO1 = 2'h3;
  localparam logic [1:0] PH_RESET = PH_HI0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int DLL_STOP_NS = 30;
  localparam int DLL_STOP_RAW = (DLL_STOP_NS * CLK_MHZ + 999) / 1000;
  localparam int DLL_STOP_CYC = (DLL_STOP_RAW < 1) ? 1 : DLL_STOP_RAW;
  localparam int LOCK_K_CYCLES_DEF = 1024;
  localparam int TURN_NOPS_DEF = 2;       // one is the least, two is safer
  localparam logic [1:0] GAP_MAX = 2'h3;  // saturating read-to-write gap
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  localparam logic LOAD_IDLE = 1'b1;
  localparam logic [1:0] LANES_OFF = 2'h3;
  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_LOCK, ST_RUN, ST_STOP} link_state_t;
endpackage

//--- verilog/sram_host.sv
// host controller driving a two-word burst double-rate sram
//
// How it works
// - read: select high, strobe low at rise
// - reads may issue every rise, always complete
// - write: select low, strobe low at rise
// - word one at next rise, two at complement
// - writes may issue on every rise
// - active-low lane selects sent with each word
// - both output clocks high selects single clock
// - at least one idle cycle read to write
// - each bank needs its own load strobe
// - stopping clocks 30 ns resets the loop
`timescale 1ns/10ps
`default_nettype none

module sram_host #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W_DEF,
  parameter int LOCK_K_CYCLES = sram_host_pkg::LOCK_K_CYCLES_DEF,
  parameter int TURN_NOPS = sram_host_pkg::TURN_NOPS_DEF,
  parameter bit SINGLE_CLOCK = 1'b0,
  parameter bit DLL_ON = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  // user command port
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [sram_host_pkg::DATA_W-1:0] i_wr_data0,
  input wire logic [sram_host_pkg::DATA_W-1:0] i_wr_data1,
  input wire logic [sram_host_pkg::LANES-1:0] i_wr_lane_en0,
  input wire logic [sram_host_pkg::LANES-1:0] i_wr_lane_en1,
  output logic o_rd_valid,
  output logic [sram_host_pkg::DATA_W-1:0] o_rd_data0,
  output logic [sram_host_pkg::DATA_W-1:0] o_rd_data1,
  input wire logic i_dll_restart,
  output logic o_link_ready,
  // sram pins
  output logic o_k,
  output logic o_k_n,
  output logic o_c,
  output logic o_c_n,
  output logic o_load_strobe_n,
  output logic o_read_write,
  output logic [ADDR_W-1:0] o_addr,
  output logic [sram_host_pkg::LANES-1:0] o_byte_write_select_n,
  output logic [sram_host_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic [sram_host_pkg::DATA_W-1:0] i_dq,
  output logic o_loop_disable_n
);
  localparam int DW = sram_host_pkg::DATA_W;
  localparam int NL = sram_host_pkg::LANES;
  localparam int LW = $clog2(LOCK_K_CYCLES + 1);
  localparam int SW = $clog2(sram_host_pkg::DLL_STOP_CYC + 1);
  localparam logic [LW-1:0] LOCK_DONE = LW'(LOCK_K_CYCLES);
  localparam logic [SW-1:0] STOP_DONE = SW'(sram_host_pkg::DLL_STOP_CYC);
  localparam logic [1:0] TURN_GAP = 2'(TURN_NOPS);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  sram_host_pkg::link_state_t st_r, st_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic k_r, kn_r;
  logic [LW-1:0] lock_cnt_r;
  logic [SW-1:0] stop_cnt_r;
  logic ld_n_r, rw_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DW-1:0] pend_w1_r, pend_w2_r, hold_w2_r, dq_r;
  logic [NL-1:0] pend_b1_r, pend_b2_r, hold_b2_r, bws_n_r;
  logic dq_oe_r;
  logic [2:0] rd_pipe_r;
  logic [1:0] wr_pipe_r;
  logic [1:0] gap_r;
  logic [DW-1:0] q_s1_r, q_s2_r, rd_w1_r, rd_d0_r, rd_d1_r;
  logic rd_valid_r;

  // ------------------------------------------------------------------
  // decode of phase, state and command
  // ------------------------------------------------------------------
  wire logic at_hi0 = (ph_r == sram_host_pkg::PH_HI0);
  wire logic at_lo0 = (ph_r == sram_host_pkg::PH_LO0);
  wire logic at_lo1 = (ph_r == sram_host_pkg::PH_LO1);
  wire logic run = (st_r == sram_host_pkg::ST_RUN);
  wire logic stop_nxt = (st_nxt == sram_host_pkg::ST_STOP);
  wire logic k_rise = at_lo1 && !stop_nxt;
  wire logic busy = (|rd_pipe_r) || (|wr_pipe_r) || !ld_n_r;
  wire logic gap_ok = (gap_r >= TURN_GAP);
  wire logic take = i_cmd_valid && o_cmd_ready;
  wire logic take_wr = take && !i_cmd_read;
  wire logic pin_rd = !ld_n_r && rw_r;  // read on pins at this rise
  wire logic pin_wr = !ld_n_r && !rw_r;  // write on pins at this rise
  wire logic lock_hit = (lock_cnt_r == LOCK_DONE);
  wire logic stop_hit = (stop_cnt_r == STOP_DONE);

  // one command slot per link clock period, reads back to back
  assign o_cmd_ready = run && at_lo0 && (i_cmd_read || gap_ok);
  assign o_link_ready = run;

  // ------------------------------------------------------------------
  // link state machine
  // ------------------------------------------------------------------
  // lock wait after reset and after a clock stop, stop on request
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      sram_host_pkg::ST_LOCK: begin
        if (!DLL_ON || (lock_hit && k_rise)) begin
          st_nxt = sram_host_pkg::ST_RUN;
        end
      end
      sram_host_pkg::ST_RUN: begin
        if (i_dll_restart && at_lo1 && !busy) begin
          st_nxt = sram_host_pkg::ST_STOP;
        end
      end
      sram_host_pkg::ST_STOP: begin
        if (stop_hit) begin
          st_nxt = sram_host_pkg::ST_LOCK;
        end
      end
    endcase
  end

  // phase advances except while the clocks stand still
  assign ph_nxt = stop_nxt ? ph_r : ph_r + 2'h1;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_r <= sram_host_pkg::ST_LOCK;
      ph_r <= sram_host_pkg::PH_RESET;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
    end
  end

  // lock and stop counters, lock counts link clock rises
  always_ff @(posedge i_clock) begin
    if (!i_nrst || st_r != sram_host_pkg::ST_LOCK) begin
      lock_cnt_r <= '0;
    end else if (k_rise && !lock_hit) begin
      lock_cnt_r <= lock_cnt_r + LW'(1);
    end
    if (!i_nrst || st_r != sram_host_pkg::ST_STOP) begin
      stop_cnt_r <= '0;
    end else if (!stop_hit) begin
      stop_cnt_r <= stop_cnt_r + SW'(1);
    end
  end

  // ------------------------------------------------------------------
  // link clocks
  // ------------------------------------------------------------------
  // divided clock pair, both held high while stopped
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      k_r <= 1'b1;
      kn_r <= 1'b0;
    end else begin
      k_r <= stop_nxt | ~ph_nxt[1];
      kn_r <= stop_nxt | ph_nxt[1];
    end
  end

  assign o_k = k_r;
  assign o_k_n = kn_r;
  // output clocks follow the input pair, or strap single clock mode
  assign o_c = SINGLE_CLOCK ? 1'b1 : k_r;
  assign o_c_n = SINGLE_CLOCK ? 1'b1 : kn_r;
  assign o_loop_disable_n = DLL_ON;

  // ------------------------------------------------------------------
  // command pins
  // ------------------------------------------------------------------
  // launched a quarter period before the rise, idle when nothing taken
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ld_n_r <= sram_host_pkg::LOAD_IDLE;
      rw_r <= 1'b1;
      addr_r <= '0;
    end else if (at_lo0) begin
      ld_n_r <= !take;
      if (take) begin
        rw_r <= i_cmd_read;
        addr_r <= i_cmd_addr;
      end
    end
  end

  assign o_load_strobe_n = ld_n_r;
  assign o_read_write = rw_r;
  assign o_addr = addr_r;

  // ------------------------------------------------------------------
  // burst tracking
  // ------------------------------------------------------------------
  // one bit per command, shifted at every link clock rise
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rd_pipe_r <= '0;
      wr_pipe_r <= '0;
      gap_r <= sram_host_pkg::GAP_MAX;
    end else if (k_rise) begin
      rd_pipe_r <= {rd_pipe_r[1:0], pin_rd};
      wr_pipe_r <= {wr_pipe_r[0], pin_wr};
      if (pin_rd) begin
        gap_r <= '0;
      end else if (gap_r != sram_host_pkg::GAP_MAX) begin
        gap_r <= gap_r + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // write data
  // ------------------------------------------------------------------
  // accepted write data waits here until its command is on the pins
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pend_w1_r <= '0;
      pend_w2_r <= '0;
      pend_b1_r <= '0;
      pend_b2_r <= '0;
    end else if (take_wr) begin
      pend_w1_r <= i_wr_data0;
      pend_w2_r <= i_wr_data1;
      pend_b1_r <= i_wr_lane_en0;
      pend_b2_r <= i_wr_lane_en1;
    end
  end

  // word one before the next rise, word two before the complement rise
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      dq_r <= '0;
      dq_oe_r <= 1'b0;
      bws_n_r <= sram_host_pkg::LANES_OFF;
      hold_w2_r <= '0;
      hold_b2_r <= '0;
    end else if (at_lo0) begin
      dq_oe_r <= wr_pipe_r[0];
      if (wr_pipe_r[0]) begin
        dq_r <= pend_w1_r;
        bws_n_r <= ~pend_b1_r;
        hold_w2_r <= pend_w2_r;
        hold_b2_r <= pend_b2_r;
      end else begin
        bws_n_r <= sram_host_pkg::LANES_OFF;
      end
    end else if (at_hi0 && wr_pipe_r[1]) begin
      dq_r <= hold_w2_r;
      bws_n_r <= ~hold_b2_r;
    end
  end

  assign o_dq = dq_r;
  assign o_dq_oe = dq_oe_r;
  assign o_byte_write_select_n = bws_n_r;

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // data pins pass two flops before capture
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q_s1_r <= '0;
      q_s2_r <= '0;
    end else begin
      q_s1_r <= i_dq;
      q_s2_r <= q_s1_r;
    end
  end

  // word one seen after t+1 complement rise, word two after t+2 rise
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rd_w1_r <= '0;
      rd_d0_r <= '0;
      rd_d1_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= at_lo0 && rd_pipe_r[2];
      if (at_hi0 && rd_pipe_r[2]) begin
        rd_w1_r <= q_s2_r;
      end
      if (at_lo0 && rd_pipe_r[2]) begin
        rd_d0_r <= rd_w1_r;
        rd_d1_r <= q_s2_r;
      end
    end
  end

  assign o_rd_valid = rd_valid_r;
  assign o_rd_data0 = rd_d0_r;
  assign o_rd_data1 = rd_d1_r;

endmodule // sram_host

`default_nettype wire

//--- verilog/_unused_guard.sv
// empty compilation unit kept out of the design
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- tb/sram_host_props.sv
// concurrent checks on the sram host ports
`timescale 1ns/10ps
`default_nettype none
module sram_host_props #(
  parameter int ADDR_W = 21
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [17:0] i_wr_data0,
  input wire logic [17:0] i_wr_data1,
  input wire logic [1:0] i_wr_lane_en0,
  input wire logic [1:0] i_wr_lane_en1,
  input wire logic o_rd_valid,
  input wire logic o_k,
  input wire logic o_load_strobe_n,
  input wire logic o_read_write,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [1:0] o_byte_write_select_n,
  input wire logic [17:0] o_dq,
  input wire logic o_dq_oe
);
  // ----------
  // pin and read answer checks
  // ----------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  // user port takes
  wire take_rd = i_cmd_valid && o_cmd_ready && i_cmd_read;
  wire take_wr = i_cmd_valid && o_cmd_ready && !i_cmd_read;
  // write words with their lane selects
  sequence s_word1;
    o_dq_oe && o_dq == $past(i_wr_data0, 5)
      && o_byte_write_select_n == ~$past(i_wr_lane_en0, 5);
  endsequence
  sequence s_word2;
    o_dq_oe && o_dq == $past(i_wr_data1, 7)
      && o_byte_write_select_n == ~$past(i_wr_lane_en1, 7);
  endsequence
  a_read_cmd: assert property (take_rd |=> !o_load_strobe_n && o_read_write
    && o_addr == $past(i_cmd_addr)) else $error("bad read command");
  a_write_cmd: assert property (take_wr |=> !o_load_strobe_n && !o_read_write
    && o_addr == $past(i_cmd_addr)) else $error("bad write command");
  a_read_answer: assert property (take_rd |-> ##13 o_rd_valid)
    else $error("read answer late");
  a_answer_cause: assert property (o_rd_valid |-> $past(take_rd, 13))
    else $error("answer without read");
  a_write_words: assert property (take_wr |-> ##5 s_word1 ##2 s_word2)
    else $error("bad write words");
  a_read_turn: assert property ($rose(o_k) && !o_load_strobe_n && o_read_write
    |-> ##4 !o_dq_oe[*8] ##1 !o_dq_oe) else $error("bus contention");
  a_lanes_idle: assert property (!o_dq_oe |-> o_byte_write_select_n == 2'h3)
    else $error("lane select without data");
  a_pins_steady: assert property ($rose(o_k)
    |-> $stable(o_load_strobe_n) && $stable(o_addr) && $stable(o_dq))
    else $error("pins move at k rise");
endmodule  // sram_host_props
bind sram_host sram_host_props #(.ADDR_W(ADDR_W)) sram_host_props_i (.*);
`default_nettype wire

//--- tb/sram_dev_model.sv
// behavioural burst sram seen from the host pins
`timescale 1ns/10ps
`default_nettype none
module sram_dev_model (
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_strobe_n,
  input wire logic i_rw,
  input wire logic [20:0] i_addr,
  input wire logic [1:0] i_ln_n,
  input wire logic [17:0] i_hd,
  input wire logic i_hoe,
  output wire logic [17:0] o_bus
);
  // ----------
  // sixteen words only, the bench stays below address 16
  // ----------
  logic [17:0] mem [0:15];
  logic [17:0] q = 18'h0;
  logic q_oe = 1'b0;  // bus released at power up
  logic wp1 = 1'b0, wp2 = 1'b0, rp1 = 1'b0, rp2 = 1'b0;
  logic [3:0] wa, wa2, ra1, ra2;
  // merges a word under active-low lane selects
  function automatic logic [17:0] lane(input logic [17:0] old, d);
    return {i_ln_n[1] ? old[17:9] : d[17:9], i_ln_n[0] ? old[8:0] : d[8:0]};
  endfunction
  // write commands and write word one on the k rise
  always @(posedge i_k) begin
    if (wp1) mem[wa] = lane(mem[wa], i_hd);
    wp2 = wp1;
    wa2 = wa;
    wp1 = !i_strobe_n && !i_rw;
    wa = i_addr[3:0];
  end
  // write word two on the complement rise at the inverted lsb
  always @(posedge i_k_n) begin
    if (wp2) mem[wa2 ^ 4'h1] = lane(mem[wa2 ^ 4'h1], i_hd);
  end
  // read words on the output clocks, released after the next c rise
  always @(posedge i_c) begin
    q_oe = rp2;
    if (rp2) q = mem[ra2 ^ 4'h1];
    rp2 = rp1;
    ra2 = ra1;
    rp1 = !i_strobe_n && i_rw;
    ra1 = i_addr[3:0];
  end
  always @(posedge i_c_n) begin
    if (rp2) begin
      q = mem[ra2];
      q_oe = 1'b1;
    end
  end
  // echo clocks are not modelled: capture is timed from the host pair
  // impedance recalibration leaves these pins untouched
  // host drive wins, a released line shows the inverse of its last value
  assign o_bus = i_hoe ? i_hd : (q_oe ? q : ~q);
endmodule  // sram_dev_model
`default_nettype wire

//--- tb/sram_host_bench.sv
// self-checking bench of the sram host against the burst sram model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module sram_host_bench;
  // ----------
  // wiring
  // ----------
  logic i_clock = 1'b0, i_nrst = 1'b0, i_cmd_valid = 1'b0, i_cmd_read = 1'b0;
  logic i_dll_restart = 1'b0;  // relock requested only at the end
  logic [20:0] i_cmd_addr = 21'h0;
  logic [17:0] i_wr_data0 = 18'h0, i_wr_data1 = 18'h0;
  logic [1:0] i_wr_lane_en0 = 2'h0, i_wr_lane_en1 = 2'h0;
  wire [17:0] o_rd_data0, o_rd_data1, o_dq, i_dq;
  wire [20:0] o_addr;
  wire [1:0] o_byte_write_select_n;
  wire o_cmd_ready, o_rd_valid, o_link_ready, o_k, o_k_n, o_c, o_c_n;
  wire o_load_strobe_n, o_read_write, o_dq_oe, o_loop_disable_n;
  int bad_count = 0;
  int total_checks = 0;
  logic [17:0] shadow [0:15];
  logic [35:0] expq [$];
  logic [35:0] got;
  // clock
  always #50 i_clock = ~i_clock;
  sram_host #(.LOCK_K_CYCLES(4)) sram_host_i (.*);
  sram_dev_model sram_dev_model_i (.i_k(o_k), .i_k_n(o_k_n), .i_c(o_c), .i_c_n(o_c_n),
    .i_strobe_n(o_load_strobe_n), .i_rw(o_read_write), .i_addr(o_addr),
    .i_ln_n(o_byte_write_select_n), .i_hd(o_dq), .i_hoe(o_dq_oe), .o_bus(i_dq));
  // ----------
  // tasks
  // ----------
  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // expected word after a lane-masked write
  function automatic logic [17:0] merge(input logic [17:0] old, d, input logic [1:0] en);
    return {en[1] ? d[17:9] : old[17:9], en[0] ? d[8:0] : old[8:0]};
  endfunction
  // one command held until taken; valid stays up for the next call
  task automatic op(input logic rd, input logic [3:0] a, input logic [1:0] e0, e1);
    int n;
    logic [17:0] d0, d1;
    d0 = 18'($urandom);
    d1 = 18'($urandom);
    if (rd) begin
      expq.push_back({shadow[a], shadow[a ^ 4'h1]});
    end else begin
      shadow[a] = merge(shadow[a], d0, e0);
      shadow[a ^ 4'h1] = merge(shadow[a ^ 4'h1], d1, e1);
    end
    i_cmd_valid = 1'b1;
    i_cmd_read = rd;
    i_cmd_addr = {17'h0, a};
    i_wr_data0 = d0;
    i_wr_data1 = d1;
    i_wr_lane_en0 = e0;
    i_wr_lane_en1 = e1;
    for (n = 0; n < 40 && o_cmd_ready !== 1'b1; n++) @(negedge i_clock);
    if (n == 40) begin
      bad_count++;
      stop_test;
    end
    @(negedge i_clock);
  endtask
  // returned bursts against the expected queue
  always @(negedge i_clock) begin
    if (o_rd_valid === 1'b1) begin
      `CHK(expq.size() > 0, 1'b1)  // each answer has a read
      if (expq.size() > 0) begin
        got = expq.pop_front();
        `CHK({o_rd_data0, o_rd_data1}, got)  // word pair in burst order
      end
    end
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    int n;
    logic [3:0] a;
    logic [1:0] e;
    n = $urandom(53);
    repeat (3) @(negedge i_clock);
    i_nrst = 1'b1;
    @(negedge i_clock);
    `CHK(o_load_strobe_n, 1'b1)  // deselected after reset
    `CHK(o_dq_oe, 1'b0)  // bus released after reset
    for (n = 0; n < 200 && o_link_ready !== 1'b1; n++) @(negedge i_clock);
    `CHK(o_link_ready, 1'b1)  // lock wait ends
    if (o_link_ready !== 1'b1) stop_test;
    `CHK(o_loop_disable_n, 1'b1)  // loop kept on
    for (n = 0; n < 16; n += 2) op(1'b0, n[3:0], 2'h3, 2'h3);  // back to back writes
    repeat (24) begin
      a = 4'($urandom);
      e = 2'($urandom);
      op(1'b0, a, e, ~e);  // random lane codes
      if ($urandom % 2) op(1'b1, a, 2'h0, 2'h0);  // read right after write
    end
    for (n = 0; n < 4; n++) op(1'b0, 4'h6, n[1:0], 2'h3 - n[1:0]);  // every lane code
    for (n = 0; n < 16; n++) op(1'b1, n[3:0], 2'h0, 2'h0);  // odd and even starts
    op(1'b0, 4'h9, 2'h1, 2'h2);  // write right after reads
    op(1'b1, 4'h8, 2'h0, 2'h0);
    i_cmd_valid = 1'b0;
    for (n = 0; n < 100 && expq.size() > 0; n++) @(negedge i_clock);
    `CHK(expq.size(), 0)  // every read answered
    repeat (8) @(negedge i_clock);
    `CHK(o_dq_oe, 1'b0)  // idle bus left released
    // clock stop and relock, then one write and read through the new lock
    i_dll_restart = 1'b1;
    for (n = 0; n < 40 && o_link_ready !== 1'b0; n++) @(negedge i_clock);
    `CHK({o_k, o_k_n, o_c, o_c_n}, 4'hf)  // clocks held high while stopped
    i_dll_restart = 1'b0;
    for (n = 0; n < 200 && o_link_ready !== 1'b1; n++) @(negedge i_clock);
    `CHK(o_link_ready, 1'b1)  // lock wait after the stop
    op(1'b0, 4'h3, 2'h3, 2'h3);
    op(1'b1, 4'h3, 2'h0, 2'h0);
    i_cmd_valid = 1'b0;
    for (n = 0; n < 100 && expq.size() > 0; n++) @(negedge i_clock);
    `CHK(expq.size(), 0)  // read after relock answered
    stop_test;
  end
endmodule  // sram_host_bench
`default_nettype wire
